// >>> verilog/adc_serial_result_readout.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Output changes on falling clock, sampled rising
// - First result byte is all zeros
// - Second byte: zero, then MSB to bit5
// - Third byte: low bits then zeros
// - Unipolar result coded straight binary
// - Bipolar result coded two's complement
// - Code centred on its nominal input level
// - Control sampled rising; first high is start
// - Convert on eighth fall; twelve decisions follow
// - Output released when chip select rises
module adc_serial_result_readout (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  output logic             dout,
  output logic             doutOe,
  // Converter core side: rounded sample code, straight binary
  input  wire logic [11:0] sampleCode,
  // Status
  output logic             busy,
  output logic             convStart,
  output logic [7:0]       ctrlByte,
  output logic [11:0]      lastResult
);

  logic sclkS;
  logic csNS;
  logic dinS;

  // Every bit of state outside the pin synchronisers lives in one packed record, registered in one place
  typedef struct packed {
    adc_readout_pkg::phase_t phase;
    logic                    sclkPrev;
    logic [2:0]              bitCnt;
    logic [7:0]              shiftIn;
    logic [4:0]              fallCnt;
    logic [4:0]              decCnt;     // Result decisions already shifted out
    logic [11:0]             result;
    logic [7:0]              ctrl;
    logic [11:0]             lastRes;
    logic                    dout;
    logic                    oe;
    logic                    startP;
    logic                    busy;       // Framing active, registered
  } state_t;

  state_t st_q;
  state_t st_d;

  // Bring the link pins into the core clock domain, one two-stage
  // synchroniser per pin; a pin edge reaches the logic two to three cycles
  // late, so the link clock must stay well below a tenth of the core clock
  logic [2:0] pinRaw;
  logic [2:0] pinSyncd;
  assign pinRaw = {sclk, csN, din};

  for (genvar g = 0; g < $bits(pinRaw); g++) begin : genSync
    pin_sync uSync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pinIn    (pinRaw[g]),
      .pinOut   (pinSyncd[g])
    );
  end

  assign sclkS = pinSyncd[2];
  assign csNS  = pinSyncd[1];
  assign dinS  = pinSyncd[0];

  // Edge detect on the synchronised clock; the history bit resets low like
  // the idle clock, so no false edge appears after reset
  logic riseEdge;
  logic fallEdge;
  assign riseEdge = sclkS & ~st_q.sclkPrev;
  assign fallEdge = ~sclkS & st_q.sclkPrev;

  // Word loaded at conversion start: straight binary for a unipolar range,
  // the MSB flipped into two's complement for a bipolar one
  logic        bipolarSel;
  logic [11:0] codedSample;
  assign bipolarSel  = st_q.ctrl[adc_readout_pkg::CTRL_BIPOLAR];
  assign codedSample = bipolarSel ? (sampleCode ^ adc_readout_pkg::BIPOLAR_FLIP)
                                  : sampleCode;

  // Decision bookkeeping: the count rests at the decision total between
  // conversions, so spare falls only ever shift out zeros
  logic decPending;
  logic restartOk;
  assign decPending = (st_q.decCnt < adc_readout_pkg::DEC_FALLS);
  // A start bit seen before result bit 4 is out is ignored, not an abort
  assign restartOk  = (st_q.decCnt >= adc_readout_pkg::RESTART_IDX);

  // Next-state logic for framing, control capture and result shifting;
  // deselect wins over any edge, so a frame cut short always ends cleanly
  // and leaves the output released
  always_comb begin
    st_d          = st_q;
    st_d.sclkPrev = sclkS;
    st_d.startP   = 1'b0;
    if (csNS) begin
      // Chip select high: release output, drop any framing
      st_d.oe     = 1'b0;
      st_d.dout   = 1'b0;
      st_d.phase   = adc_readout_pkg::ST_IDLE;
      st_d.bitCnt  = 3'h0;
      st_d.fallCnt = 5'h00;
      st_d.decCnt  = adc_readout_pkg::DEC_FALLS;
    end else begin
      st_d.oe = 1'b1;
      if (riseEdge) begin
        // Control input sampled on rising edge
        case (st_q.phase)
          adc_readout_pkg::ST_IDLE: begin
            // First high bit after select is the start bit
            if (dinS) begin
              st_d.phase   = adc_readout_pkg::ST_CTRL;
              st_d.shiftIn = 8'h01;
              st_d.bitCnt  = 3'h1;
              st_d.fallCnt = 5'h00;
            end
          end
          adc_readout_pkg::ST_CTRL: begin
            // Seven more control bits follow the start bit
            st_d.shiftIn = {st_q.shiftIn[6:0], dinS};
            st_d.bitCnt  = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == 3'h7) begin
              st_d.ctrl = {st_q.shiftIn[6:0], dinS};
            end
          end
          adc_readout_pkg::ST_CONV: begin
            // A fresh start bit is honoured once result bit 4 is out; the
            // remaining decisions keep shifting out under the new byte
            if (dinS && restartOk) begin
              st_d.phase   = adc_readout_pkg::ST_CTRL;
              st_d.shiftIn = 8'h01;
              st_d.bitCnt  = 3'h1;
              st_d.fallCnt = 5'h00;
            end
          end
          default: begin
            // Unused code: fall back to idle
            st_d.phase = adc_readout_pkg::ST_IDLE;
          end
        endcase
      end else if (fallEdge) begin
        // Output moves on falling edges only; pending decisions go out MSB
        // first and keep going while a new control byte is framed, so the
        // tail of one result overlaps the next control byte
        if (decPending) begin
          st_d.dout   = st_q.result[11];
          st_d.result = {st_q.result[10:0], 1'b0};
          st_d.decCnt = st_q.decCnt + 5'h01;
        end else begin
          // Nothing pending: leading and trailing zeros
          st_d.dout = 1'b0;
        end
        // The eighth fall after the start bit ends acquisition
        case (st_q.phase)
          adc_readout_pkg::ST_CTRL: begin
            st_d.fallCnt = st_q.fallCnt + 5'h01;
            if (st_q.fallCnt + 5'h01 == adc_readout_pkg::ACQ_FALLS) begin
              // Load the coded word and keep a copy for the status port
              st_d.phase   = adc_readout_pkg::ST_CONV;
              st_d.fallCnt = 5'h00;
              st_d.startP  = 1'b1;
              st_d.result  = codedSample;
              st_d.lastRes = codedSample;
              st_d.decCnt  = 5'h00;
              st_d.dout    = 1'b0;
            end
          end
          default: begin
            st_d.fallCnt = st_q.fallCnt;
          end
        endcase
      end
    end
    // Busy is registered with the phase, so the port comes from a flop
    // and never glitches while the phase decodes
    st_d.busy = (st_d.phase != adc_readout_pkg::ST_IDLE);
  end

  // State register; reset clears the result words and parks the decision
  // count at its end, so frames before the first conversion clock out
  // zeros only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{phase:   adc_readout_pkg::ST_IDLE,
                result:  adc_readout_pkg::RESULT_RESET,
                lastRes: adc_readout_pkg::RESULT_RESET,
                decCnt:  adc_readout_pkg::DEC_FALLS,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register, with no logic after the
  // flops, so the host sees clean levels on every port
  assign dout       = st_q.dout;
  assign doutOe     = st_q.oe;
  assign busy       = st_q.busy;
  assign convStart  = st_q.startP;
  assign ctrlByte   = st_q.ctrl;
  assign lastResult = st_q.lastRes;

endmodule : adc_serial_result_readout

`default_nettype wire

// >>> verilog/adc_readout_pkg.sv
package adc_readout_pkg;

  // Result and framing widths
  localparam int RESULT_WIDTH  = 12;
  localparam int CTRL_WIDTH    = 8;
  localparam int CTRL_BIPOLAR  = 3;          // Control byte bit selecting bipolar coding
  localparam int CTRL_START    = 7;          // Control byte start bit position
  // Edge counts after the start bit
  localparam logic [4:0] ACQ_FALLS   = 5'h08;  // Conversion starts on the eighth falling edge
  localparam logic [4:0] DEC_FALLS   = 5'h0C;  // Twelve decisions follow
  localparam logic [4:0] RESTART_IDX = 5'h08;  // Decisions out once result bit 4 stands
  // Code offset that turns straight binary into two's complement
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CTRL,
    ST_CONV
  } phase_t;

endpackage : adc_readout_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Asynchronous pin and its synchronised copy
  input  wire logic pinIn,
  output logic      pinOut
);

  logic metaQ;
  logic syncQ;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      metaQ <= 1'b0;
      syncQ <= 1'b0;
    end else begin
      metaQ <= pinIn;
      syncQ <= metaQ;
    end
  end

  assign pinOut = syncQ;

endmodule : pin_sync

`default_nettype wire

// >>> bench/adc_readout_props.sv
`timescale 1ns/10ps
`default_nettype none
module adc_readout_props (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Watched ports
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic       dout,
  input wire logic       doutOe,
  input wire logic       busy,
  input wire logic       convStart,
  input wire logic [7:0] ctrlByte
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  oe_release_a: assert property ($rose(csN) |-> ##[1:5] !doutOe)
    else $error("dout driven after deselect");
  oe_drive_a: assert property (!csN [*6] |-> doutOe)
    else $error("dout not driven while selected");
  conv_pulse_a: assert property (convStart |=> !convStart)
    else $error("conversion pulse too long");
  conv_busy_a: assert property (convStart |-> busy && !csN)
    else $error("conversion outside a frame");
  dout_fall_a: assert property ($changed(dout) |-> !sclk)
    else $error("dout moved while clock high");
  dout_hold_a: assert property ($rose(sclk) |=> $stable(dout) [*4])
    else $error("dout moved after rising clock");
  lead_zero_a: assert property (convStart |-> !dout)
    else $error("leading bits not zero");
  start_bit_a: assert property (convStart |-> ctrlByte[7])
    else $error("control byte lacks start bit");
endmodule : adc_readout_props
bind adc_serial_result_readout adc_readout_props u_props (.core_clk(core_clk), .nrst(nrst),
  .sclk(sclk), .csN(csN), .dout(dout), .doutOe(doutOe), .busy(busy),
  .convStart(convStart), .ctrlByte(ctrlByte));
`default_nettype wire

// >>> bench/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Serial link pins
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout
);
  // Clock idles low, device deselected
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end
  // Zeros, control byte, zeros; duplex shift, capture on rise
  task automatic xfer(input logic [7:0] ctrl, input int lead, input int n,
                      output logic [23:0] rx);
    rx = 24'h000000;
    csN <= 1'b0;
    for (int i = 0; i < lead + n; i++) begin
      din <= (i >= lead && i < lead + 8) ? ctrl[7 - i + lead] : 1'b0;
      #62.5 sclk <= 1'b1;
      rx = {rx[22:0], dout};
      #62.5 sclk <= 1'b0;
    end
    #250 csN <= 1'b1;
    // Stay deselected long enough for the device to see the gap
    #250;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        core_clk, nrst, sclk, csN, din, dout, doutOe, busy, convStart;
  logic [11:0] sampleCode, lastResult;
  logic [7:0]  ctrlByte;
  logic [23:0] rx;
  int          fail_count, tests_run, cycles;
  adc_serial_result_readout u_dut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
    .csN(csN), .din(din), .dout(dout), .doutOe(doutOe), .sampleCode(sampleCode),
    .busy(busy), .convStart(convStart), .ctrlByte(ctrlByte), .lastResult(lastResult));
  spi_host_model u_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout));
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [23:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // One full readout with a given core code
  task automatic readout(input logic [7:0] ctrl, input logic [11:0] code, exp, input int lead);
    @(posedge core_clk) sampleCode <= code;
    u_host.xfer(ctrl, lead, 24, rx);
    check("frame", rx, {9'h000, exp, 3'h0});
    check("joined", {12'h000, rx[14:8], rx[7:3]}, {12'h000, exp});
    check("last", {12'h000, lastResult}, {12'h000, exp});
    check("ctrl", {16'h0000, ctrlByte}, {16'h0000, ctrl});
  endtask : readout
  task automatic test_unipolar;
    readout(8'h80, 12'hA5C, 12'hA5C, 0);
    readout(8'h80, 12'hFFF, 12'hFFF, 0);
    $display("unipolar done");
  endtask : test_unipolar
  task automatic test_bipolar;
    readout(8'h88, 12'h000, 12'h800, 0);
    readout(8'h88, 12'hFFF, 12'h7FF, 0);
    $display("bipolar done");
  endtask : test_bipolar
  task automatic test_lead;
    readout(8'h80, 12'h001, 12'h001, 16);
    $display("lead zeros done");
  endtask : test_lead
  task automatic test_abort;
    @(posedge core_clk) sampleCode <= 12'h3C3;
    u_host.xfer(8'h80, 0, 12, rx);
    repeat (8) @(posedge core_clk);
    check("abort last", {12'h000, lastResult}, 24'h0003C3);
    check("release", {22'h000000, doutOe, busy}, 24'h000000);
    $display("abort done");
  endtask : test_abort
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Reset, then scenarios
  initial begin
    nrst = 1'b0;
    sampleCode = 12'h000;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    test_unipolar();
    test_bipolar();
    test_abort();
    test_lead();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
